// File: cfg_regs_pkg.sv
// shared offsets, field positions and types for the dram/bus configuration registers
package cfg_regs_pkg;
   localparam logic [7:0] OFF_NC3_HI   = 8'h11;
   localparam logic [7:0] OFF_DRAM_CTL = 8'h12;
   localparam logic [7:0] OFF_RELOC    = 8'h13;
   localparam logic [7:0] OFF_BUS_CTL  = 8'h14;

   localparam logic [7:0] RST_NC3_HI   = 8'h00;
   localparam logic [7:0] RST_DRAM_CTL = 8'h00;
   localparam logic [7:0] RST_RELOC    = 8'h00;
   localparam logic [7:0] RST_BUS_CTL  = 8'h00;

   // writable masks; reserved bits ignore writes and read zero
   localparam logic [7:0] WMASK_DRAM_CTL = 8'hf7;
   localparam logic [7:0] WMASK_BUS_CTL  = 8'hd9;

   localparam int DRAM_RCD_BIT    = 7;
   localparam int DRAM_CASPRE_BIT = 6;
   localparam int DRAM_ROM_BIT    = 5;
   localparam int DRAM_SPEED_BIT  = 4;
   localparam int DRAM_4MX4_BIT   = 2;
   localparam int DRAM_MCFG_LSB   = 0;

   localparam int BUS_BUS_SIZE_16_N_OFF_BIT = 7;
   localparam int BUS_CWH_0WS_BIT  = 6;
   localparam int BUS_8B_0WS_BIT   = 4;
   localparam int BUS_16B_0WS_BIT  = 3;
   localparam int BUS_NO32_BIT     = 0;

   localparam int NUM_STROBES = 4;

   localparam logic [2:0] RCD_SLOW   = 3'h3;
   localparam logic [2:0] RCD_FAST   = 3'h2;
   localparam logic [2:0] CASPRE_LEN = 3'h2;
   localparam logic [2:0] CASPRE_STD = 3'h1;

   localparam logic [23:0] ROM_BASE_64K  = 24'hff0000;
   localparam logic [23:0] ROM_BASE_256K = 24'hfc0000;
   localparam logic [23:0] ROM_BASE_512K = 24'hf80000;

   typedef enum logic [3:0] {
      ROM_OFF    = 4'h1,
      ROM_64K    = 4'h2,
      ROM_256K   = 4'h4,
      ROM_512K   = 4'h8
   } rom_size_e;

   typedef enum logic [2:0] {
      SPEED_FULL  = 3'h1,
      SPEED_SLOW  = 3'h2,
      SPEED_SLEEP = 3'h4
   } speed_sel_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_s;

   typedef struct packed {
      logic [7:0] nc3_hi;
      logic [7:0] dram_ctl;
      logic [7:0] reloc;
      logic [7:0] bus_ctl;
      logic [7:0] rdata;
   } reg_state_s;

   typedef struct packed {
      logic [7:0]  nc3_addr_en;
      logic [2:0]  rcd_cycles;
      logic [2:0]  cas_precharge_cycles;
      rom_size_e   rom_size;
      logic [23:0] rom_base;
      logic        rom_enable;
      logic        speed_pin_sleep_mode;
      logic        dram_4mx4_en;
      logic [5:0]  mem_cfg;
      logic [7:0]  bank_of_strobe;
      logic        bus_size_16_n_oe;
      logic        cache_wr_hit_0ws;
      logic        bus8_0ws;
      logic        bus16_0ws;
      logic        bus32_disable;
      speed_sel_e  speed_sel;
      logic [3:0]  row_strobe_out_n;
   } ctl_out_s;
endpackage

// File: bank_reloc.sv
// maps each row strobe onto its relocated bank
`timescale 1ns/1ps
module bank_reloc
   import cfg_regs_pkg::*;
(
   // relocation fields and strobes
   input  wire logic [7:0] reloc,
   input  wire logic [3:0] strobe_in_n,
   // results
   output logic [7:0]      bank_of_strobe,
   output logic [3:0]      bank_strobe_n
);
   logic [3:0] hit [NUM_STROBES];

   genvar n;
   generate
      for (n = 0; n < NUM_STROBES; n++) begin : g_strobe
         logic [1:0] bank;
         // 2-bit add wraps, giving modulo 4 for free
         assign bank = 2'(n) + reloc[2*n +: 2];
         assign bank_of_strobe[2*n +: 2] = bank;
         assign hit[n] = strobe_in_n[n] ? 4'h0 : (4'h1 << bank);
      end
   endgenerate

   assign bank_strobe_n = ~(hit[0] | hit[1] | hit[2] | hit[3]);
endmodule

// File: cfg_regs.sv
// dram, rom, speed pin and expansion bus configuration register bank
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
//
// What this block does
// - region 3 high-address enable bits 7..0 add lines A25..A18 to compare.
// - row-to-column delay bit selects three read cycles, else two.
// - column precharge bit holds column strobe precharge two cycles on reads.
// - rom bit with config 0 bit 6 picks off, 64K, 256K or 512K.
// - speed-pin mode bit picks sleep clock, else slow clock, against full speed.
// - large-dram bit enables 4Mx4 dram support.
// - dram control bits 1-0 are memory configuration bits 5 and 4.
// - each row strobe goes to bank (n plus field) modulo 4.
// - bus control bit 7 stops driving the 16-bit bus size output.
// - bus control bit 6 gives zero-wait cache write hits.
// - bus control bit 4 gives zero-wait 8-bit expansion cycles.
// - bus control bit 3 gives zero-wait 16-bit expansion cycles.
// - bus control bit 0 stops 32-bit expansion bus cycles.
module cfg_regs
   import cfg_regs_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   // fields from companion registers 0h and 8h
   input  wire logic       rom_size_lo,
   input  wire logic [3:0] mem_cfg_lo,
   // pins
   input  wire logic       speed_pin,
   input  wire logic [3:0] row_strobe_in_n,
   input  wire logic       bus_size_16_req_n,
   // controls
   output logic [7:0]      nc3_addr_en,
   output logic [2:0]      rcd_cycles,
   output logic [2:0]      cas_precharge_cycles,
   output rom_size_e       rom_size,
   output logic [23:0]     rom_base,
   output logic            rom_enable,
   output logic            dram_4mx4_en,
   output logic [5:0]      mem_cfg,
   output logic [7:0]      bank_of_strobe,
   output logic            cache_wr_hit_0ws,
   output logic            bus8_0ws,
   output logic            bus16_0ws,
   output logic            bus32_disable,
   output speed_sel_e      speed_sel,
   // row strobes after relocation, bus size pin
   output logic            row_strobe_0_n,
   output logic            row_strobe_1_n,
   output logic            row_strobe_2_n,
   output logic            row_strobe_3_n,
   output logic            bus_size_16_n_o,
   output logic            bus_size_16_n_oe
);
   reg_state_s st_q, st_d;
   ctl_out_s   out_q, out_d;
   reg_req_s   req;
   logic [1:0] speed_sync_q;
   logic [7:0] reloc_map;
   logic [3:0] bank_n;
   logic       bus_size_16_n_q;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   bank_reloc u_reloc (
      .reloc          (st_q.reloc),
      .strobe_in_n    (row_strobe_in_n),
      .bank_of_strobe (reloc_map),
      .bank_strobe_n  (bank_n)
   );

   always_comb begin
      st_d = st_q;
      st_d.rdata = 8'h00;
      if (req.wr) begin
         unique case (req.addr)
            OFF_NC3_HI:   st_d.nc3_hi = req.wdata;
            OFF_DRAM_CTL: st_d.dram_ctl = req.wdata & WMASK_DRAM_CTL;
            OFF_RELOC:    st_d.reloc = req.wdata;
            OFF_BUS_CTL:  st_d.bus_ctl = req.wdata & WMASK_BUS_CTL;
            default:      st_d.rdata = 8'h00;
         endcase
      end
      if (req.rd) begin
         unique case (req.addr)
            OFF_NC3_HI:   st_d.rdata = st_q.nc3_hi;
            OFF_DRAM_CTL: st_d.rdata = st_q.dram_ctl;
            OFF_RELOC:    st_d.rdata = st_q.reloc;
            OFF_BUS_CTL:  st_d.rdata = st_q.bus_ctl;
            default:      st_d.rdata = 8'h00;
         endcase
      end
   end

   always_comb begin
      out_d = out_q;
      out_d.nc3_addr_en = st_q.nc3_hi;
      out_d.rcd_cycles = st_q.dram_ctl[DRAM_RCD_BIT] ? RCD_SLOW : RCD_FAST;
      out_d.cas_precharge_cycles = st_q.dram_ctl[DRAM_CASPRE_BIT] ? CASPRE_LEN : CASPRE_STD;
      unique case ({st_q.dram_ctl[DRAM_ROM_BIT], rom_size_lo})
         2'b00: begin
            out_d.rom_size = ROM_OFF;
            out_d.rom_base = ROM_BASE_64K;
         end
         2'b01: begin
            out_d.rom_size = ROM_64K;
            out_d.rom_base = ROM_BASE_64K;
         end
         2'b10: begin
            out_d.rom_size = ROM_256K;
            out_d.rom_base = ROM_BASE_256K;
         end
         2'b11: begin
            out_d.rom_size = ROM_512K;
            out_d.rom_base = ROM_BASE_512K;
         end
      endcase
      out_d.rom_enable = st_q.dram_ctl[DRAM_ROM_BIT] | rom_size_lo;
      out_d.speed_pin_sleep_mode = st_q.dram_ctl[DRAM_SPEED_BIT];
      // pin high asks for full speed; low drops to the mode-chosen clock
      if (speed_sync_q[1])
         out_d.speed_sel = SPEED_FULL;
      else if (st_q.dram_ctl[DRAM_SPEED_BIT])
         out_d.speed_sel = SPEED_SLEEP;
      else
         out_d.speed_sel = SPEED_SLOW;
      out_d.dram_4mx4_en = st_q.dram_ctl[DRAM_4MX4_BIT];
      out_d.mem_cfg = {st_q.dram_ctl[DRAM_MCFG_LSB +: 2], mem_cfg_lo};
      out_d.bank_of_strobe = reloc_map;
      out_d.row_strobe_out_n = bank_n;
      out_d.bus_size_16_n_oe = ~st_q.bus_ctl[BUS_BUS_SIZE_16_N_OFF_BIT];
      out_d.cache_wr_hit_0ws = st_q.bus_ctl[BUS_CWH_0WS_BIT];
      out_d.bus8_0ws = st_q.bus_ctl[BUS_8B_0WS_BIT];
      out_d.bus16_0ws = st_q.bus_ctl[BUS_16B_0WS_BIT];
      out_d.bus32_disable = st_q.bus_ctl[BUS_NO32_BIT];
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= '{nc3_hi: RST_NC3_HI, dram_ctl: RST_DRAM_CTL, reloc: RST_RELOC,
                   bus_ctl: RST_BUS_CTL, rdata: 8'h00};
         out_q <= '{nc3_addr_en: 8'h00, rcd_cycles: RCD_FAST, cas_precharge_cycles: CASPRE_STD,
                    rom_size: ROM_OFF, rom_base: ROM_BASE_64K, rom_enable: 1'b0,
                    speed_pin_sleep_mode: 1'b0, dram_4mx4_en: 1'b0, mem_cfg: 6'h00,
                    bank_of_strobe: 8'he4, bus_size_16_n_oe: 1'b1, cache_wr_hit_0ws: 1'b0,
                    bus8_0ws: 1'b0, bus16_0ws: 1'b0, bus32_disable: 1'b0,
                    speed_sel: SPEED_FULL, row_strobe_out_n: 4'hf};
         // idle pin level is high; a zero here would fake a slow-down after reset
         speed_sync_q <= 2'h3;
         bus_size_16_n_q <= 1'b1;
      end else begin
         st_q <= st_d;
         out_q <= out_d;
         // pin synchroniser: stage 0 feeds only stage 1
         speed_sync_q <= {speed_sync_q[0], speed_pin};
         bus_size_16_n_q <= bus_size_16_req_n;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign nc3_addr_en = out_q.nc3_addr_en;
   assign rcd_cycles = out_q.rcd_cycles;
   assign cas_precharge_cycles = out_q.cas_precharge_cycles;
   assign rom_size = out_q.rom_size;
   assign rom_base = out_q.rom_base;
   assign rom_enable = out_q.rom_enable;
   assign dram_4mx4_en = out_q.dram_4mx4_en;
   assign mem_cfg = out_q.mem_cfg;
   assign bank_of_strobe = out_q.bank_of_strobe;
   assign cache_wr_hit_0ws = out_q.cache_wr_hit_0ws;
   assign bus8_0ws = out_q.bus8_0ws;
   assign bus16_0ws = out_q.bus16_0ws;
   assign bus32_disable = out_q.bus32_disable;
   assign speed_sel = out_q.speed_sel;
   assign row_strobe_0_n = out_q.row_strobe_out_n[0];
   assign row_strobe_1_n = out_q.row_strobe_out_n[1];
   assign row_strobe_2_n = out_q.row_strobe_out_n[2];
   assign row_strobe_3_n = out_q.row_strobe_out_n[3];
   assign bus_size_16_n_o = bus_size_16_n_q;
   assign bus_size_16_n_oe = out_q.bus_size_16_n_oe;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence wr_bus_s(int b);
      reg_wr && reg_addr == OFF_BUS_CTL && reg_wdata[b];
   endsequence

   nc3_follow_a: assert property (reg_wr && reg_addr == OFF_NC3_HI |-> ##2 nc3_addr_en == $past(reg_wdata, 2))
      else $error("region 3 enables do not follow write");
   rcd_sel_a: assert property (##1 rcd_cycles == ($past(st_q.dram_ctl[DRAM_RCD_BIT]) ? 3'h3 : 3'h2))
      else $error("row to column delay wrong");
   caspre_a: assert property (##1 (cas_precharge_cycles == 3'h2) == $past(st_q.dram_ctl[DRAM_CASPRE_BIT]))
      else $error("precharge length wrong");
   rom_512k_a: assert property (st_q.dram_ctl[DRAM_ROM_BIT] && rom_size_lo |=> rom_base == 24'hf80000)
      else $error("512K rom base wrong");
   speed_mode_a: assert property (!speed_pin [*3] ##0 st_q.dram_ctl[DRAM_SPEED_BIT] [*2]
                                  |=> speed_sel == SPEED_SLEEP)
      else $error("speed pin did not select sleep clock");
   mcfg_a: assert property (##1 mem_cfg[5:4] == $past(st_q.dram_ctl[1:0]))
      else $error("memory config bits 5 and 4 wrong");
   reloc_a: assert property (##1 bank_of_strobe[3:2] == 2'($past(st_q.reloc[3:2]) + 2'h1))
      else $error("strobe 1 relocation wrong");
   bus_size_16_n_off_a: assert property (wr_bus_s(BUS_BUS_SIZE_16_N_OFF_BIT) |-> ##2 !bus_size_16_n_oe)
      else $error("bus size output still driven");
   cwh_a: assert property (wr_bus_s(BUS_CWH_0WS_BIT) |-> ##2 cache_wr_hit_0ws)
      else $error("cache write hit zero wait not set");
   b8_a: assert property (wr_bus_s(BUS_8B_0WS_BIT) |-> ##2 bus8_0ws)
      else $error("8-bit zero wait not set");
   b16_a: assert property (wr_bus_s(BUS_16B_0WS_BIT) |-> ##2 bus16_0ws)
      else $error("16-bit zero wait not set");
   no32_a: assert property (wr_bus_s(BUS_NO32_BIT) |-> ##2 bus32_disable)
      else $error("32-bit disable not set");
   rsvd_a: assert property (##1 st_q.bus_ctl[5] == 1'b0 && st_q.dram_ctl[3] == 1'b0)
      else $error("reserved bit took a write");
endmodule

// File: dram_bus_model.sv
// far side: dram bank selects and the pulled-up bus size line
`timescale 1ns/1ps
module dram_bus_model (
   // relocated row strobes
   input  wire logic  row_strobe_0_n,
   input  wire logic  row_strobe_1_n,
   input  wire logic  row_strobe_2_n,
   input  wire logic  row_strobe_3_n,
   // bus size pin
   input  wire logic  bus_size_16_n_o,
   input  wire logic  bus_size_16_n_oe,
   // what the far side sees
   output logic [3:0] bank_active,
   output logic       bus_size_16_wire_n
);
   assign bank_active = ~{row_strobe_3_n, row_strobe_2_n, row_strobe_1_n, row_strobe_0_n};
   // a released line floats up through its pull-up, never holds the last value
   assign bus_size_16_wire_n = bus_size_16_n_oe ? bus_size_16_n_o : 1'b1;
endmodule

// File: tb.sv
// self-checking bench for the dram/bus configuration register bank
`timescale 1ns/1ps
module tb;
   import cfg_regs_pkg::*;
   logic        sys_clk, resetn, reg_wr, reg_rd, rom_size_lo, speed_pin, bs_req_n;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, nc3_addr_en, bank_of_strobe;
   logic [3:0]  mem_cfg_lo, rs_in_n, bank_active;
   logic [2:0]  rcd, pre;
   logic [23:0] rom_base;
   logic [5:0]  mem_cfg;
   rom_size_e   rom_size;
   speed_sel_e  speed_sel;
   logic        rom_en, big_en, cwh, b8, b16, no32, rs0, rs1, rs2, rs3, bs_o, bs_oe, bs_w;
   int          n_mismatch = 0;
   int          checks_done = 0;

   cfg_regs u_cfg_regs (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rom_size_lo(rom_size_lo),
      .mem_cfg_lo(mem_cfg_lo), .speed_pin(speed_pin), .row_strobe_in_n(rs_in_n),
      .bus_size_16_req_n(bs_req_n), .nc3_addr_en(nc3_addr_en), .rcd_cycles(rcd),
      .cas_precharge_cycles(pre), .rom_size(rom_size), .rom_base(rom_base), .rom_enable(rom_en),
      .dram_4mx4_en(big_en), .mem_cfg(mem_cfg), .bank_of_strobe(bank_of_strobe),
      .cache_wr_hit_0ws(cwh), .bus8_0ws(b8), .bus16_0ws(b16), .bus32_disable(no32),
      .speed_sel(speed_sel), .row_strobe_0_n(rs0), .row_strobe_1_n(rs1), .row_strobe_2_n(rs2),
      .row_strobe_3_n(rs3), .bus_size_16_n_o(bs_o), .bus_size_16_n_oe(bs_oe));

   dram_bus_model u_dram_bus_model (.row_strobe_0_n(rs0), .row_strobe_1_n(rs1), .row_strobe_2_n(rs2),
      .row_strobe_3_n(rs3), .bus_size_16_n_o(bs_o), .bus_size_16_n_oe(bs_oe),
      .bank_active(bank_active), .bus_size_16_wire_n(bs_w));

   task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(nm, reg_rdata, exp);
   endtask

   task automatic settle;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   task automatic t_reset;
      chk("rcd", rcd, RCD_FAST);
      chk("rom", rom_size, ROM_OFF);
      chk("speed", speed_sel, SPEED_FULL);
      chk("banks", bank_of_strobe, 8'he4);
      chk("bs_oe", bs_oe, 1'b1);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("speed", speed_sel, SPEED_FULL);
      rd_chk("r11", OFF_NC3_HI, 8'h00);
      rd_chk("r12", OFF_DRAM_CTL, 8'h00);
      rd_chk("r13", OFF_RELOC, 8'h00);
      rd_chk("r14", OFF_BUS_CTL, 8'h00);
   endtask

   task automatic t_addr_en;
      wr_reg(OFF_NC3_HI, 8'ha5);
      rd_chk("r11", OFF_NC3_HI, 8'ha5);
      wr_reg(8'h15, 8'hff);
      rd_chk("unmapped", 8'h15, 8'h00);
      settle();
      chk("nc3", nc3_addr_en, 8'ha5);
   endtask

   task automatic t_dram;
      wr_reg(OFF_DRAM_CTL, 8'hff);
      rd_chk("r12", OFF_DRAM_CTL, 8'hf7);
      settle();
      chk("rcd", rcd, 3'h3);
      chk("pre", pre, 3'h2);
      chk("4mx4", big_en, 1'b1);
      chk("mcfg", mem_cfg, 6'h39);
      wr_reg(OFF_DRAM_CTL, 8'h00);
      settle();
      chk("rcd", rcd, 3'h2);
      chk("pre", pre, CASPRE_STD);
      chk("4mx4", big_en, 1'b0);
      chk("mcfg", mem_cfg, 6'h09);
   endtask

   task automatic t_rom;
      rom_size_e   rs[4] = '{ROM_OFF, ROM_64K, ROM_256K, ROM_512K};
      logic [23:0] rb[4] = '{24'hff0000, 24'hff0000, 24'hfc0000, 24'hf80000};
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         rom_size_lo <= i[0];
         wr_reg(OFF_DRAM_CTL, {2'b00, i[1], 5'h00});
         settle();
         chk("rom", rom_size, rs[i]);
         chk("base", rom_base, rb[i]);
         chk("rom_en", rom_en, i != 0);
      end
   endtask

   task automatic t_speed;
      for (int m = 0; m < 2; m++) begin
         wr_reg(OFF_DRAM_CTL, {3'b000, m[0], 4'h0});
         @(posedge sys_clk);
         speed_pin <= 1'b0;
         settle();
         chk("speed", speed_sel, m ? SPEED_SLEEP : SPEED_SLOW);
         @(posedge sys_clk);
         speed_pin <= 1'b1;
         settle();
         chk("speed", speed_sel, SPEED_FULL);
      end
   endtask

   task automatic t_reloc;
      logic [7:0] e;
      for (int f = 0; f < 4; f++) begin
         for (int n = 0; n < 4; n++) e[2*n +: 2] = 2'((f + 2*n) % 4);
         wr_reg(OFF_RELOC, {2'(f + 3), 2'(f + 2), 2'(f + 1), 2'(f)});
         settle();
         chk("banks", bank_of_strobe, e);
         for (int n = 0; n < 4; n++) begin
            @(posedge sys_clk);
            rs_in_n <= ~(4'h1 << n);
            repeat (2) @(posedge sys_clk);
            #1;
            chk("bank_hit", bank_active, 4'h1 << ((f + 2*n) % 4));
            @(posedge sys_clk);
            rs_in_n <= 4'hf;
         end
      end
   endtask

   task automatic bus_chk(input logic [7:0] d, input logic [5:0] e);
      wr_reg(OFF_BUS_CTL, d);
      settle();
      chk("cwh", cwh, e[5]);
      chk("b8", b8, e[4]);
      chk("b16", b16, e[3]);
      chk("no32", no32, e[2]);
      chk("bs_oe", bs_oe, e[1]);
      chk("bs_wire", bs_w, e[0]);
   endtask

   task automatic end_sim;
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   initial begin
      #20000;
      n_mismatch++;
      end_sim();
   end

   initial begin
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      rom_size_lo = 1'b0;
      mem_cfg_lo = 4'h9;
      speed_pin = 1'b1;
      rs_in_n = 4'hf;
      bs_req_n = 1'b0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      #1;
      t_reset();
      t_addr_en();
      t_dram();
      t_rom();
      t_speed();
      t_reloc();
      wr_reg(OFF_BUS_CTL, 8'hff);
      rd_chk("r14", OFF_BUS_CTL, 8'hd9);
      bus_chk(8'h51, 6'b110_110);
      @(posedge sys_clk);
      bs_req_n <= 1'b1;
      settle();
      chk("bs_wire", bs_w, 1'b1);
      @(posedge sys_clk);
      bs_req_n <= 1'b0;
      bus_chk(8'h88, 6'b001_001);
      end_sim();
   end
endmodule
